//--- rtl/wtx_pkg.sv
`default_nettype none
package wtx_pkg;
    // register indices; byte address on the bus is four times the index
    localparam logic [6:0] IDX_DIE_LIM = 7'h1a;
    localparam logic [6:0] IDX_FAN0 = 7'h1c;
    localparam logic [6:0] IDX_FAN1 = 7'h1d;
    localparam logic [6:0] IDX_FAN2 = 7'h1e;
    localparam logic [6:0] IDX_FAN3 = 7'h1f;
    localparam logic [6:0] IDX_TECH = 7'h20;
    localparam logic [6:0] IDX_MAXW_BASE = 7'h21;
    localparam logic [6:0] IDX_MAXW_ALT = 7'h22;
    localparam logic [6:0] IDX_MAXW_RES = 7'h23;
    localparam logic [6:0] IDX_COIL = 7'h40;
    localparam logic [6:0] IDX_PSTATE = 7'h41;
    localparam logic [6:0] IDX_NEG_TECH = 7'h42;
    localparam logic [6:0] IDX_AGREED = 7'h43;
    localparam logic [6:0] IDX_FOD = 7'h44;
    localparam logic [6:0] IDX_RX_PSTATE = 7'h45;
    localparam logic [6:0] IDX_FREQ = 7'h46;
    localparam logic [6:0] IDX_DUTY = 7'h48;
    localparam logic [6:0] IDX_VBR = 7'h4a;
    localparam logic [6:0] IDX_IBR = 7'h4c;
    localparam logic [6:0] IDX_COIL_V = 7'h4e;
    localparam logic [6:0] IDX_COIL_I = 7'h50;
    localparam logic [6:0] IDX_TCOIL = 7'h52;
    localparam logic [6:0] IDX_TDIE = 7'h54;
    localparam logic [6:0] IDX_PDC = 7'h56;
    localparam logic [6:0] IDX_GUARD = 7'h60;
    // guard status fields
    localparam int GST_ERR_BIT = 0;
    localparam int GST_HALT_BIT = 1;
    // technology bit count and field widths
    localparam int TECH_BITS = 5;
    localparam int FOD_BITS = 4;
    // reset values
    localparam logic [4:0] TECH_PERMIT_RST = 5'h1f;
    localparam logic [7:0] MAXW_RST = 8'hff;
    localparam logic [15:0] DIE_LIM_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
endpackage
`default_nettype wire

//--- rtl/wtx_guard_if.sv
`default_nettype none
// limit, live die reading and clear go to the guard; verdict comes back
interface wtx_guard_if;
    logic [15:0] limit;
    logic [15:0] die_temp;
    logic err_clr;
    logic err;
    logic halt;
    modport guard (input limit, input die_temp, input err_clr, output err, output halt);
    modport bank (output limit, output die_temp, output err_clr, input err, input halt);
endinterface
`default_nettype wire

//--- rtl/wtx_temp_guard.sv
`default_nettype none
module wtx_temp_guard (
    input wire logic clk_sys,
    input wire logic rst_n,
    wtx_guard_if.guard gif
);
    // whole state of the guard
    typedef struct packed {
        logic err;
        logic halt;
    } wtx_guard_t;

    wtx_guard_t q;
    wtx_guard_t d;
    logic over; // reading strictly above a nonzero limit

    ////////////////////////////////////////////////////////////////////////
    // comparison and sticky error
    always_comb begin
        d = q;
        over = (gif.limit != 16'h0000) && (gif.die_temp > gif.limit);
        // clear first, so a new trip in the same cycle wins
        if (gif.err_clr) begin
            d.err = 1'b0;
        end
        if (over) begin
            d.err = 1'b1;
        end
        // transfer stays halted while the error is latched
        d.halt = d.err;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign gif.err = q.err;
    assign gif.halt = q.halt;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_DIE_TRIP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (gif.limit != 16'h0000 && gif.die_temp > gif.limit) |=> (gif.err && gif.halt))
        else $error("over temperature did not halt transfer");
    AST_ZERO_LIMIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (gif.limit == 16'h0000 && !gif.err) |=> !gif.err)
        else $error("zero limit still tripped");
endmodule
`default_nettype wire

//--- rtl/wtx_reg_bank.sv
`default_nettype none
// How it works
// - halt and flag error above die limit
// - zero limit disables the die check
// - technology register reads hardware capability bits
// - technology permitted only if its permit bit is set (all set at reset) and capable
// - max power reads hardware, allowed is the smaller of the written value and the hardware figure
// - active coil index readable as binary
// - transmitter power state code readable
// - negotiated technology code readable
// - agreed power level readable in watts
// - foreign object methods bits readable
// - switching frequency readable, 100 Hz steps
// - duty cycle readable, 0.01 percent steps
// - bridge supply voltage readable in millivolts
// - bridge supply current readable in milliamps
// - coil thermistor temperature readable
module wtx_reg_bank #(
    parameter int TECHS = wtx_pkg::TECH_BITS,
    parameter int FODS = wtx_pkg::FOD_BITS
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [8:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [TECHS-1:0] HW_CAPS,
    input wire logic [7:0] HW_MAXW_BASE,
    input wire logic [7:0] HW_MAXW_ALT,
    input wire logic [7:0] HW_MAXW_RES,
    input wire logic [7:0] ACTIVE_COIL,
    input wire logic [7:0] TX_POWER_STATE,
    input wire logic [7:0] NEGOTIATED_TECH,
    input wire logic [7:0] AGREED_WATTS,
    input wire logic [FODS-1:0] FOD_METHODS,
    input wire logic [15:0] SWITCHING_FREQUENCY,
    input wire logic [15:0] SWITCHING_DUTY,
    input wire logic [15:0] BRIDGE_MILLIVOLTS,
    input wire logic [15:0] BRIDGE_MILLIAMPS,
    input wire logic [15:0] COIL_PEAK_VOLTS,
    input wire logic [15:0] COIL_RMS_MILLIAMPS,
    input wire logic [15:0] COIL_TEMPERATURE,
    input wire logic [15:0] CHIP_TEMPERATURE,
    input wire logic [15:0] BRIDGE_INPUT_POWER,
    output logic [TECHS-1:0] TECH_ALLOW,
    output logic [7:0] MAXW_ALLOW_BASE,
    output logic [7:0] MAXW_ALLOW_ALT,
    output logic [7:0] MAXW_ALLOW_RES,
    output logic OVERTEMP_ERR,
    output logic TX_HALT
);
    // whole state of the bank
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic [7:0] snap;          // low byte held for the pair read
        logic [7:0] lim_stage;     // high byte of limit waiting for its low half
        logic [15:0] die_lim;
        logic [TECHS-1:0] permit;  // what software allows
        logic [7:0] maxw_base;
        logic [7:0] maxw_alt;
        logic [7:0] maxw_res;
        logic [3:0][7:0] fan;      // reserved bytes, kept so they read back
        logic err_clr;
        logic [TECHS-1:0] tech_allow;
        logic [7:0] allow_base;
        logic [7:0] allow_alt;
        logic [7:0] allow_res;
    } wtx_bank_t;

    wtx_bank_t q;
    wtx_bank_t d;
    wtx_guard_if gif ();
    logic req;      // bus request present
    logic [6:0] idx; // word index of the access
    logic [15:0] wide_now; // pair value at the addressed index

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // sixteen-bit register whose high byte sits at this index
    function automatic logic pair_hi(input logic [6:0] i);
        pair_hi = (i == wtx_pkg::IDX_DIE_LIM) ||
                  (i >= wtx_pkg::IDX_FREQ && i <= wtx_pkg::IDX_PDC && !i[0]);
    endfunction

    // value of the sixteen-bit register starting at this index
    function automatic logic [15:0] wide_val(input logic [6:0] i);
        case (i)
            wtx_pkg::IDX_DIE_LIM: wide_val = q.die_lim;
            wtx_pkg::IDX_FREQ: wide_val = SWITCHING_FREQUENCY;
            wtx_pkg::IDX_DUTY: wide_val = SWITCHING_DUTY;
            wtx_pkg::IDX_VBR: wide_val = BRIDGE_MILLIVOLTS;
            wtx_pkg::IDX_IBR: wide_val = BRIDGE_MILLIAMPS;
            wtx_pkg::IDX_COIL_V: wide_val = COIL_PEAK_VOLTS;
            wtx_pkg::IDX_COIL_I: wide_val = COIL_RMS_MILLIAMPS;
            wtx_pkg::IDX_TCOIL: wide_val = COIL_TEMPERATURE;
            wtx_pkg::IDX_TDIE: wide_val = CHIP_TEMPERATURE;
            wtx_pkg::IDX_PDC: wide_val = BRIDGE_INPUT_POWER;
            default: wide_val = 16'h0000;
        endcase
    endfunction

    // smaller of the written cap and the hardware cap
    function automatic logic [7:0] cap(input logic [7:0] want, input logic [7:0] hw);
        cap = (want < hw) ? want : hw;
    endfunction

    // full read word for an index
    function automatic logic [31:0] read_word(input logic [6:0] i);
        logic [15:0] wv; // whole pair value, sliced below
        wv = wide_val(i);
        case (i)
            wtx_pkg::IDX_FAN0: read_word = {24'h000000, q.fan[0]};
            wtx_pkg::IDX_FAN1: read_word = {24'h000000, q.fan[1]};
            wtx_pkg::IDX_FAN2: read_word = {24'h000000, q.fan[2]};
            wtx_pkg::IDX_FAN3: read_word = {24'h000000, q.fan[3]};
            wtx_pkg::IDX_TECH: read_word = 32'(HW_CAPS);
            wtx_pkg::IDX_MAXW_BASE: read_word = {24'h000000, HW_MAXW_BASE};
            wtx_pkg::IDX_MAXW_ALT: read_word = {24'h000000, HW_MAXW_ALT};
            wtx_pkg::IDX_MAXW_RES: read_word = {24'h000000, HW_MAXW_RES};
            wtx_pkg::IDX_COIL: read_word = {24'h000000, ACTIVE_COIL};
            wtx_pkg::IDX_PSTATE: read_word = {24'h000000, TX_POWER_STATE};
            wtx_pkg::IDX_NEG_TECH: read_word = {24'h000000, NEGOTIATED_TECH};
            wtx_pkg::IDX_AGREED: read_word = {24'h000000, AGREED_WATTS};
            wtx_pkg::IDX_FOD: read_word = 32'(FOD_METHODS);
            wtx_pkg::IDX_GUARD: begin
                read_word = 32'h0000_0000;
                read_word[wtx_pkg::GST_ERR_BIT] = gif.err;
                read_word[wtx_pkg::GST_HALT_BIT] = gif.halt;
            end
            default: begin
                // pair halves; everything else, reserved receiver byte included, is zero
                if (pair_hi(i)) begin
                    read_word = {24'h000000, wv[15:8]};
                end else if (i[0] && pair_hi(i - 7'h01)) begin
                    read_word = {24'h000000, q.snap};
                end else begin
                    read_word = 32'h0000_0000;
                end
            end
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // bus slave and register update
    always_comb begin
        d = q;
        d.err_clr = 1'b0;
        req = WB_CYC_I && WB_STB_I;
        idx = WB_ADR_I[8:2];
        wide_now = wide_val(idx);
        // ack one cycle after the request, dropped the cycle after
        d.ack = req && !q.ack;
        if (req && !q.ack) begin
            d.dat = read_word(idx);
            // capture the low half with the high half, so no torn pair
            if (pair_hi(idx)) begin
                d.snap = wide_now[7:0];
            end
        end
        // writes take effect on the edge where the master sees ack
        if (req && q.ack && WB_WE_I && WB_SEL_I[0]) begin
            case (idx)
                wtx_pkg::IDX_DIE_LIM: d.lim_stage = WB_DAT_I[7:0];
                // low half commits both bytes at once, so the guard never sees half
                wtx_pkg::IDX_DIE_LIM + 7'h01: d.die_lim = {q.lim_stage, WB_DAT_I[7:0]};
                wtx_pkg::IDX_FAN0: d.fan[0] = WB_DAT_I[7:0];
                wtx_pkg::IDX_FAN1: d.fan[1] = WB_DAT_I[7:0];
                wtx_pkg::IDX_FAN2: d.fan[2] = WB_DAT_I[7:0];
                wtx_pkg::IDX_FAN3: d.fan[3] = WB_DAT_I[7:0];
                wtx_pkg::IDX_TECH: d.permit = WB_DAT_I[TECHS-1:0];
                wtx_pkg::IDX_MAXW_BASE: d.maxw_base = WB_DAT_I[7:0];
                wtx_pkg::IDX_MAXW_ALT: d.maxw_alt = WB_DAT_I[7:0];
                wtx_pkg::IDX_MAXW_RES: d.maxw_res = WB_DAT_I[7:0];
                // write one to the error bit to clear it
                wtx_pkg::IDX_GUARD: d.err_clr = WB_DAT_I[wtx_pkg::GST_ERR_BIT];
                default: d.err_clr = 1'b0;
            endcase
        end
        // permission needs capability too; follows capability changes live
        d.tech_allow = d.permit & HW_CAPS;
        d.allow_base = cap(d.maxw_base, HW_MAXW_BASE);
        d.allow_alt = cap(d.maxw_alt, HW_MAXW_ALT);
        d.allow_res = cap(d.maxw_res, HW_MAXW_RES);
    end

    // state register
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            q <= '0;
            q.die_lim <= wtx_pkg::DIE_LIM_RST;
            q.permit <= wtx_pkg::TECH_PERMIT_RST;
            q.maxw_base <= wtx_pkg::MAXW_RST;
            q.maxw_alt <= wtx_pkg::MAXW_RST;
            q.maxw_res <= wtx_pkg::MAXW_RST;
            q.dat <= wtx_pkg::WORD_RST;
            q.snap <= wtx_pkg::BYTE_RST;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // die temperature guard
    assign gif.limit = q.die_lim;
    assign gif.die_temp = CHIP_TEMPERATURE;
    assign gif.err_clr = q.err_clr;

    wtx_temp_guard u_guard (
        .clk_sys(CLK_SYS),
        .rst_n(RSTN),
        .gif(gif.guard)
    );

    // outputs, all from flops
    assign WB_DAT_O = q.dat;
    assign WB_ACK_O = q.ack;
    assign TECH_ALLOW = q.tech_allow;
    assign MAXW_ALLOW_BASE = q.allow_base;
    assign MAXW_ALLOW_ALT = q.allow_alt;
    assign MAXW_ALLOW_RES = q.allow_res;
    assign OVERTEMP_ERR = gif.err;
    assign TX_HALT = gif.halt;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_TECH_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && !WB_WE_I && idx == wtx_pkg::IDX_TECH)
        |=> (WB_ACK_O && WB_DAT_O == 32'($past(HW_CAPS))))
        else $error("technology read wrong");
    AST_TECH_GATE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && q.ack && WB_WE_I && WB_SEL_I[0] && idx == wtx_pkg::IDX_TECH)
        |=> (TECH_ALLOW == ($past(WB_DAT_I[TECHS-1:0]) & $past(HW_CAPS))))
        else $error("technology permit not gated by capability");
    AST_MAXW_CAP: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && q.ack && WB_WE_I && WB_SEL_I[0] && idx == wtx_pkg::IDX_MAXW_BASE)
        |=> (MAXW_ALLOW_BASE <= $past(WB_DAT_I[7:0]) && MAXW_ALLOW_BASE <= $past(HW_MAXW_BASE)))
        else $error("allowed power exceeds request or hardware");
    AST_COIL_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_COIL)
        |=> (WB_DAT_O == {24'h000000, $past(ACTIVE_COIL)}))
        else $error("active coil read wrong");
    AST_STATE_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_PSTATE)
        |=> (WB_DAT_O == {24'h000000, $past(TX_POWER_STATE)}))
        else $error("power state read wrong");
    AST_NEG_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_NEG_TECH)
        |=> (WB_DAT_O == {24'h000000, $past(NEGOTIATED_TECH)}))
        else $error("negotiated technology read wrong");
    AST_FOD_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_FOD)
        |=> (WB_DAT_O == 32'($past(FOD_METHODS))))
        else $error("foreign object methods read wrong");
    AST_PAIR_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_FREQ)
        |=> (WB_DAT_O[7:0] == $past(SWITCHING_FREQUENCY[15:8])
             && q.snap == $past(SWITCHING_FREQUENCY[7:0])))
        else $error("pair high read or capture wrong");
    AST_ACK_ONE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    // agreed power byte passes through unchanged
    AST_AGREED_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_AGREED)
        |=> (WB_DAT_O == {24'h000000, $past(AGREED_WATTS)}))
        else $error("agreed power read wrong");

    // frequency high half on the first read of its pair
    AST_FREQ_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_FREQ)
        |=> (WB_DAT_O == {24'h000000, $past(SWITCHING_FREQUENCY[15:8])}))
        else $error("frequency high byte wrong");

    // duty high half
    AST_DUTY_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_DUTY)
        |=> (WB_DAT_O == {24'h000000, $past(SWITCHING_DUTY[15:8])}))
        else $error("duty high byte wrong");

    // bridge voltage high half
    AST_VBR_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_VBR)
        |=> (WB_DAT_O == {24'h000000, $past(BRIDGE_MILLIVOLTS[15:8])}))
        else $error("bridge voltage high byte wrong");

    // bridge current high half
    AST_IBR_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_IBR)
        |=> (WB_DAT_O == {24'h000000, $past(BRIDGE_MILLIAMPS[15:8])}))
        else $error("bridge current high byte wrong");

    // coil thermistor high half
    AST_TCOIL_HI: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_TCOIL)
        |=> (WB_DAT_O == {24'h000000, $past(COIL_TEMPERATURE[15:8])}))
        else $error("coil temperature high byte wrong");

    // die reading low half frozen together with its high half
    AST_TDIE_SNAP: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_TDIE)
        |=> (q.snap == $past(CHIP_TEMPERATURE[7:0])))
        else $error("die low byte not captured");

    // held low byte never drifts between taken requests
    AST_SNAP_HOLD: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !(req && !q.ack)
        |=> $stable(q.snap))
        else $error("held low byte changed outside a read");

    // limit moves only when its low half is written
    AST_LIMIT_COMMIT: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !(req && q.ack && WB_WE_I && WB_SEL_I[0] && idx == wtx_pkg::IDX_DIE_LIM + 7'h01)
        |=> $stable(q.die_lim))
        else $error("limit changed without its low half");

    // no technology enabled without hardware capability
    AST_TECH_CAP: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        1'b1
        |=> ((TECH_ALLOW & ~$past(HW_CAPS)) == '0))
        else $error("technology allowed without capability");

    // allowed power never above what the hardware supports
    AST_MAXW_HW: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        1'b1 |=> (MAXW_ALLOW_BASE <= $past(HW_MAXW_BASE) && MAXW_ALLOW_ALT <= $past(HW_MAXW_ALT)
             && MAXW_ALLOW_RES <= $past(HW_MAXW_RES)))
        else $error("allowed power above hardware maximum");

    // guard status word mirrors the error and halt outputs
    AST_GUARD_READ: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == wtx_pkg::IDX_GUARD)
        |=> (WB_DAT_O[wtx_pkg::GST_ERR_BIT] == $past(OVERTEMP_ERR)
             && WB_DAT_O[wtx_pkg::GST_HALT_BIT] == $past(TX_HALT)))
        else $error("guard status read wrong");

    // unmapped index reads as zero
    AST_UNMAPPED_ZERO: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (req && !q.ack && idx == 7'h7f)
        |=> (WB_DAT_O == 32'h0000_0000))
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

//--- verif/wtx_tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, cyc, stb, we, ack, err, halt;
    logic [8:0] adr; // byte address, index in bits 8:2
    logic [3:0] sel;
    logic [31:0] dat_w, dat_r;
    logic [4:0] caps, allow; // capability in, permit out
    logic [2:0][7:0] hw_max, max_allow; // base, alt inductive, alt resonant
    logic [3:0][7:0] st8; // coil, tx state, technology, agreed watts
    logic [3:0] fod;
    logic [8:0][15:0] m16; // measurements in address order
    int n_errors = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////////
    wtx_reg_bank i_dut (.CLK_SYS(clk), .RSTN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r),
        .WB_ACK_O(ack), .HW_CAPS(caps), .HW_MAXW_BASE(hw_max[0]), .HW_MAXW_ALT(hw_max[1]),
        .HW_MAXW_RES(hw_max[2]), .ACTIVE_COIL(st8[0]), .TX_POWER_STATE(st8[1]),
        .NEGOTIATED_TECH(st8[2]), .AGREED_WATTS(st8[3]), .FOD_METHODS(fod),
        .SWITCHING_FREQUENCY(m16[0]), .SWITCHING_DUTY(m16[1]), .BRIDGE_MILLIVOLTS(m16[2]),
        .BRIDGE_MILLIAMPS(m16[3]), .COIL_PEAK_VOLTS(m16[4]), .COIL_RMS_MILLIAMPS(m16[5]),
        .COIL_TEMPERATURE(m16[6]), .CHIP_TEMPERATURE(m16[7]), .BRIDGE_INPUT_POWER(m16[8]),
        .TECH_ALLOW(allow), .MAXW_ALLOW_BASE(max_allow[0]), .MAXW_ALLOW_ALT(max_allow[1]),
        .MAXW_ALLOW_RES(max_allow[2]), .OVERTEMP_ERR(err), .TX_HALT(halt));
    ////////////////////////////////////////////////////////////////////////////////
    // free-running 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // verdict in one place, reached from the main sequence or the watchdog
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // pin-level compare
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // one classic cycle; ack sampled at the edge, request released only after it
    task automatic bus(input logic w, input logic [6:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {24'h000000, wd};
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (ack === 1'b1) break;
        end
        rd = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // a missing ack would otherwise hang the run
        if (n == 16) begin
            n_errors++;
            $display("BAD %0t no bus acknowledge", $time);
            complete_run();
        end
    endtask
    task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
        logic [31:0] dummy;
        bus(1'b1, idx, wd, dummy);
    endtask
    // register read compare, value sits in the low byte
    task automatic chk_rd(input logic [6:0] idx, input logic [7:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 8'h00, rd);
        cmp(rd, {24'h000000, exp}, "read data");
    endtask
    // let registered outputs land; sample away from the active edge
    task automatic settle();
        repeat (3) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("BAD %0t run did not finish", $time);
        complete_run();
    end
    // main sequence
    initial begin
        int e [4];
        int code7 [5]; // power state codes to walk through
        logic [7:0] pm, h, w;
        logic [15:0] hv;
        void'($urandom(94));
        code7 = '{1, 2, 3, 4, 6};
        {rst_n, cyc, stb, we, adr, dat_w, fod} = '0;
        sel = 4'h1;
        caps = 5'h15;
        hw_max = {8'h28, 8'h0f, 8'h05};
        st8 = '0;
        m16 = '0;
        m16[7] = 16'hffff; // hot die while the limit is zero
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        settle();
        cmp(allow, caps, "permit after reset");
        for (int k = 0; k < 3; k++) cmp(max_allow[k], hw_max[k], "max after reset");
        cmp(err, 1'b0, "zero limit");
        for (int k = 0; k < 4; k++) chk_rd(7'(wtx_pkg::IDX_FAN0 + k), 8'h00);
        // reserved fan bytes are writable and read back
        wr(7'(wtx_pkg::IDX_FAN0 + 2), 8'h3c);
        chk_rd(7'(wtx_pkg::IDX_FAN0 + 2), 8'h3c);
        chk_rd(7'h7f, 8'h00); // unmapped index reads zero
        // random capability against random permit
        for (int i = 0; i < 4; i++) begin
            pm = 8'($urandom);
            @(posedge clk);
            caps <= 5'($urandom);
            wr(wtx_pkg::IDX_TECH, pm);
            settle();
            cmp(allow, caps & pm[4:0], "technology permit");
            chk_rd(wtx_pkg::IDX_TECH, {3'b000, caps});
        end
        // per-technology cap, written below and above the hardware figure
        for (int k = 0; k < 3; k++) begin
            for (int j = 0; j < 2; j++) begin
                h = 8'($urandom_range(10, 250));
                w = j ? h + 8'h05 : h - 8'h07;
                @(posedge clk);
                hw_max[k] <= h;
                wr(7'(wtx_pkg::IDX_MAXW_BASE + k), w);
                settle();
                cmp(max_allow[k], (w < h) ? w : h, "max allowed");
                chk_rd(7'(wtx_pkg::IDX_MAXW_BASE + k), h);
            end
        end
        // every documented status code
        for (int i = 0; i < 7; i++) begin
            e = '{i, code7[i % 5], i % 6, $urandom_range(0, 255)};
            @(posedge clk);
            for (int r = 0; r < 4; r++) st8[r] <= 8'(e[r]);
            fod <= 4'(1 << (i % 4));
            for (int r = 0; r < 4; r++) begin
                chk_rd(7'(wtx_pkg::IDX_COIL + r), 8'(e[r]));
            end
            chk_rd(wtx_pkg::IDX_FOD, 8'(1 << (i % 4)));
        end
        wr(wtx_pkg::IDX_PSTATE, 8'h5a); // read-only place keeps the status
        chk_rd(wtx_pkg::IDX_PSTATE, 8'(e[1]));
        // low byte frozen by the high-byte read even when the input moves
        for (int k = 0; k < 9; k++) begin
            hv = 16'($urandom);
            @(posedge clk);
            m16[k] <= hv;
            chk_rd(7'(wtx_pkg::IDX_FREQ + 2 * k), hv[15:8]);
            @(posedge clk);
            m16[k] <= ~hv;
            chk_rd(7'(wtx_pkg::IDX_FREQ + 2 * k + 1), hv[7:0]);
        end
        // die limit 8500: staged high byte alone must not arm the check
        @(posedge clk);
        m16[7] <= 16'hffff;
        wr(wtx_pkg::IDX_DIE_LIM, 8'h21);
        settle();
        cmp(err, 1'b0, "staged limit");
        @(posedge clk);
        m16[7] <= 16'd8500;
        wr(7'(wtx_pkg::IDX_DIE_LIM + 1), 8'h34);
        settle();
        cmp(err, 1'b0, "equal to limit");
        @(posedge clk);
        m16[7] <= 16'd8501;
        @(posedge clk);
        @(negedge clk);
        cmp({halt, err}, 2'b11, "above limit");
        @(posedge clk);
        m16[7] <= 16'd100;
        settle();
        cmp({halt, err}, 2'b11, "error held");
        chk_rd(wtx_pkg::IDX_GUARD, 8'h03);
        wr(wtx_pkg::IDX_GUARD, 8'h01);
        settle();
        cmp({halt, err}, 2'b00, "error cleared");
        chk_rd(wtx_pkg::IDX_GUARD, 8'h00);
        // limit back to zero switches the check off
        wr(wtx_pkg::IDX_DIE_LIM, 8'h00);
        wr(7'(wtx_pkg::IDX_DIE_LIM + 1), 8'h00);
        @(posedge clk);
        m16[7] <= 16'hffff;
        settle();
        cmp(err, 1'b0, "check disabled");
        complete_run();
    end
endmodule
`default_nettype wire
